// ===== verilog/sfs_pkg.sv
// package: constants, types and helpers shared by the flash command sequencer
package sfs_pkg;

  // ****************************************
  // serial clock sources
  // ****************************************
  localparam int F26_KHZ = 26000;
  localparam int F13_KHZ = 13000;
  localparam int F6P5_KHZ = 6500;
  localparam int F3P25_KHZ = 3250;
  // the link clock port runs at the fastest source; slower ones are divided
  localparam int BASE_KHZ = F26_KHZ;
  localparam logic [3:0] HALF_SRC0 = 4'(BASE_KHZ / F26_KHZ);
  localparam logic [3:0] HALF_SRC1 = 4'(BASE_KHZ / F13_KHZ);
  localparam logic [3:0] HALF_SRC2 = 4'(BASE_KHZ / F6P5_KHZ);
  localparam logic [3:0] HALF_SRC3 = 4'(BASE_KHZ / F3P25_KHZ);
  localparam logic [3:0] EDGE_LAST = 4'hF;

  // ****************************************
  // command buffer, idle pattern, counts
  // ****************************************
  localparam int CMD_BYTES = 8;
  localparam logic [2:0] CNT_ALL = 3'h0;
  localparam logic [3:0] CNT_ALL_BYTES = 4'h8;
  localparam logic [1:0] PAT_ZERO = 2'h0;
  localparam logic [1:0] PAT_ONE = 2'h1;
  localparam logic [1:0] PAT_ALT = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'hFF;
  localparam logic [7:0] BYTE_ALT = 8'hAA;
  localparam logic [23:0] DCNT_ZERO = 24'h000000;
  localparam logic [23:0] DCNT_ONE = 24'h000001;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [3:0] BE_ALL = 4'hF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_RDAT = 5'h04,
    ST_WDAT = 5'h08,
    ST_FIN = 5'h10
  } sfs_state_e;

  typedef enum logic [1:0] {
    EG_IDLE = 2'h1,
    EG_SHIFT = 2'h2
  } sfs_eng_e;

  // bit reversal for lsb-first bytes
  function automatic logic [7:0] sfsRev8(input logic [7:0] b);
    logic [7:0] r;
    r = BYTE_ZERO;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : sfsRev8

  // flash byte offset to data lane: little keeps it, big mirrors it
  function automatic logic [1:0] sfsLane(input logic [1:0] off, input logic little);
    return little ? off : ~off;
  endfunction : sfsLane

endpackage : sfs_pkg

// ===== verilog/sfs_xfer_if.sv
// interface: byte handshake between sequencer and link-side shifter
interface sfs_xfer_if;
  logic reqTgl;
  logic [7:0] txByte;
  logic ackTgl;
  logic [7:0] rxByte;
  logic [1:0] mode;
  logic [1:0] clkSel;
  modport seq(output reqTgl, txByte, mode, clkSel, input ackTgl, rxByte);
  modport eng(input reqTgl, txByte, mode, clkSel, output ackTgl, rxByte);
endinterface : sfs_xfer_if

// ===== verilog/sfs_spi_engine.sv
// module: link-clock byte shifter, all four clock modes, msb first
module sfs_spi_engine
  import sfs_pkg::*;
(
  input wire logic linkClk,
  input wire logic linkRst_n,
  sfs_xfer_if.eng xf,
  input wire logic flashMiso,
  output logic flashSck,
  output logic flashMosi
);

  sfs_eng_e eg_r, eg_nxt;
  logic [2:0] reqS_r, reqS_nxt;
  logic [1:0] misoS_r, misoS_nxt;
  logic [1:0] modeS1_r, modeS2_r, selS1_r, selS2_r;
  logic [3:0] halfCnt_r, halfCnt_nxt, edgeCnt_r, edgeCnt_nxt, half;
  logic [7:0] txSh_r, txSh_nxt, rxSh_r, rxSh_nxt, rxByte_r, rxByte_nxt;
  logic sck_r, sck_nxt, mosi_r, mosi_nxt, ack_r, ack_nxt, cpol, cpha, lead;

  assign flashSck = sck_r;
  assign flashMosi = mosi_r;
  assign xf.ackTgl = ack_r;
  assign xf.rxByte = rxByte_r;

  // ****************************************
  // shifter next state
  // ****************************************
  // miso is two link cycles late; the slowest sources leave margin for that
  always_comb begin
    eg_nxt = eg_r;
    reqS_nxt = {reqS_r[1:0], xf.reqTgl};
    misoS_nxt = {misoS_r[0], flashMiso};
    halfCnt_nxt = halfCnt_r;
    edgeCnt_nxt = edgeCnt_r;
    txSh_nxt = txSh_r;
    rxSh_nxt = rxSh_r;
    rxByte_nxt = rxByte_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    ack_nxt = ack_r;
    cpol = modeS2_r[1];
    cpha = modeS2_r[0];
    lead = ~edgeCnt_r[0];
    case (selS2_r)
      2'h0: half = HALF_SRC0;
      2'h1: half = HALF_SRC1;
      2'h2: half = HALF_SRC2;
      default: half = HALF_SRC3;
    endcase
    case (eg_r)
      EG_IDLE: begin
        sck_nxt = cpol;
        if (reqS_r[2] != reqS_r[1]) begin
          txSh_nxt = xf.txByte;
          edgeCnt_nxt = '0;
          halfCnt_nxt = half - 4'h1;
          eg_nxt = EG_SHIFT;
          if (!cpha) begin
            mosi_nxt = xf.txByte[7];
          end
        end
      end
      EG_SHIFT: begin
        if (halfCnt_r == '0) begin
          halfCnt_nxt = half - 4'h1;
          sck_nxt = ~sck_r;
          edgeCnt_nxt = edgeCnt_r + 4'h1;
          if (lead != cpha) begin
            rxSh_nxt = {rxSh_r[6:0], misoS_r[1]};
          end else begin
            mosi_nxt = cpha ? txSh_r[7] : txSh_r[6];
            txSh_nxt = {txSh_r[6:0], 1'b0};
          end
          if (edgeCnt_r == EDGE_LAST) begin
            rxByte_nxt = rxSh_nxt;
            ack_nxt = ~ack_r;
            eg_nxt = EG_IDLE;
          end
        end else begin
          halfCnt_nxt = halfCnt_r - 4'h1;
        end
      end
      default: eg_nxt = EG_IDLE;
    endcase
  end

  // link registers; mode and source select cross as slow levels
  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      eg_r <= EG_IDLE;
      reqS_r <= '0;
      misoS_r <= '0;
      modeS1_r <= '0;
      modeS2_r <= '0;
      selS1_r <= '0;
      selS2_r <= '0;
      halfCnt_r <= '0;
      edgeCnt_r <= '0;
      txSh_r <= '0;
      rxSh_r <= '0;
      rxByte_r <= '0;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      eg_r <= eg_nxt;
      reqS_r <= reqS_nxt;
      misoS_r <= misoS_nxt;
      modeS1_r <= xf.mode;
      modeS2_r <= modeS1_r;
      selS1_r <= xf.clkSel;
      selS2_r <= selS1_r;
      halfCnt_r <= halfCnt_nxt;
      edgeCnt_r <= edgeCnt_nxt;
      txSh_r <= txSh_nxt;
      rxSh_r <= rxSh_nxt;
      rxByte_r <= rxByte_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      ack_r <= ack_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_sck_idle;
    @(posedge linkClk) disable iff (!linkRst_n)
      (eg_r == EG_IDLE) |=> (flashSck == $past(modeS2_r[1]));
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not at idle level");

  property p_ack_end;
    @(posedge linkClk) disable iff (!linkRst_n)
      (ack_r != $past(ack_r)) |-> ($past(eg_r) == EG_SHIFT) && (eg_r == EG_IDLE);
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack outside byte end");

  property p_sixteen_edges;
    @(posedge linkClk) disable iff (!linkRst_n)
      (eg_r == EG_SHIFT && halfCnt_r == '0 && edgeCnt_r == EDGE_LAST) |=> (eg_r == EG_IDLE);
  endproperty
  a_sixteen_edges: assert property (p_sixteen_edges) else $error("byte not ended");

endmodule : sfs_spi_engine

// ===== verilog/sfs_sequencer.sv
// module: serial flash command sequencer top with data-phase bus master
// Functional notes
// - serial clock source picks 26, 13, 6.5 or 3.25 MHz
// - two-bit mode field sets clock polarity and phase for every transfer
// - write and read bytes each selectable msb first or lsb first
// - while receiving, mosi sends zero, one, alternating, or a set byte
// - eight command bytes in two words: low holds 1-4, high 5-8
// - direction bit n belongs to byte n+1; one means transmit
// - byte with direction zero is received and stored in its slot
// - received status bytes are readable in both buffer words
// - three-bit count sets command bytes sent, starting at byte 1
// - go pulse starts a transaction exchanging the command bytes
// - done flag sets when the whole transaction, data included, ends
// - nonzero read count: receive that many bytes, write them to memory
// - nonzero write count with zero read count: fetch that many bytes from memory, send them
// - all command bytes go out before any data byte
// - endian bit: one little, zero big
// - little: flash byte 0 on lane 7:0, byte 3 on 31:24
// - big: flash byte 0 on lane 31:24, byte 3 on 7:0
// - clearing the supply switch turns off the flash power feed
// - all four clock polarity and phase modes are supported
module sfs_sequencer
  import sfs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic linkClk,
  input wire logic transactionGo,
  input wire logic doneClr,
  output logic transactionCompleteFlag,
  output logic busy,
  input wire logic cmdLowWe,
  input wire logic cmdHighWe,
  input wire logic [31:0] cmdWrData,
  output logic [31:0] commandBytesLowWord,
  output logic [31:0] commandBytesHighWord,
  input wire logic [7:0] direction,
  input wire logic [2:0] cmdCount,
  input wire logic [23:0] rdCount,
  input wire logic [23:0] wrCount,
  input wire logic [31:0] dmaAddr,
  input wire logic [1:0] xferMode,
  input wire logic [1:0] serialClockSourceSelect,
  input wire logic wrLsbFirst,
  input wire logic rdLsbFirst,
  input wire logic [1:0] idlePattern,
  input wire logic [7:0] idleByte,
  input wire logic littleEndian,
  input wire logic flashSupplySwitch,
  output logic flashPowerEn,
  output logic flashSelectLine_n,
  output logic flashSck,
  output logic flashMosi,
  input wire logic flashMiso,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [3:0] memBe,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] memRdata
);

  sfs_xfer_if xf();

  sfs_state_e st_r, st_nxt;
  logic [7:0] cmdBuf_r [CMD_BYTES];
  logic [7:0] cmdBuf_nxt [CMD_BYTES];
  logic [3:0] idx_r, idx_nxt, total;
  logic [23:0] dcnt_r, dcnt_nxt;
  logic [31:0] addr_r, addr_nxt, word_r, word_nxt;
  logic [31:0] mAddr_r, mAddr_nxt, mWdata_r, mWdata_nxt;
  logic [3:0] be_r, be_nxt, mBe_r, mBe_nxt;
  logic [2:0] ackS_r, ackS_nxt;
  logic [7:0] txByte_r, txByte_nxt, patByte, rxIn;
  logic [1:0] lane;
  logic [1:0] lrst_r;
  logic pend_r, pend_nxt, reqTgl_r, reqTgl_nxt, wvalid_r, wvalid_nxt;
  logic mReq_r, mReq_nxt, mWe_r, mWe_nxt, sel_r, sel_nxt, done_r, done_nxt;
  logic pwr_r, ackEv, lastByte;

  // ****************************************
  // link side
  // ****************************************
  // link reset asserts at once and releases on the link clock
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_r <= 2'h0;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end

  sfs_spi_engine u_engine (
    .linkClk(linkClk),
    .linkRst_n(lrst_r[1]),
    .xf(xf.eng),
    .flashMiso(flashMiso),
    .flashSck(flashSck),
    .flashMosi(flashMosi)
  );

  assign xf.reqTgl = reqTgl_r;
  assign xf.txByte = txByte_r;
  assign xf.mode = xferMode;
  assign xf.clkSel = serialClockSourceSelect;

  // ****************************************
  // outputs
  // ****************************************
  // buffer words read back straight from the byte flops
  generate
    for (genvar g = 0; g < CMD_BYTES / 2; g++) begin : g_pack
      assign commandBytesLowWord[g*8 +: 8] = cmdBuf_r[g];
      assign commandBytesHighWord[g*8 +: 8] = cmdBuf_r[g + CMD_BYTES / 2];
    end
  endgenerate

  assign transactionCompleteFlag = done_r;
  assign busy = (st_r != ST_IDLE);
  assign flashPowerEn = pwr_r;
  assign flashSelectLine_n = ~sel_r;
  assign memReq = mReq_r;
  assign memWe = mWe_r;
  assign memAddr = mAddr_r;
  assign memBe = mBe_r;
  assign memWdata = mWdata_r;

  // ****************************************
  // sequencer
  // ****************************************
  // helpers: byte count, idle pattern, received byte order, lane
  always_comb begin
    total = (cmdCount == CNT_ALL) ? CNT_ALL_BYTES : {1'b0, cmdCount};
    case (idlePattern)
      PAT_ZERO: patByte = BYTE_ZERO;
      PAT_ONE: patByte = BYTE_ONE;
      PAT_ALT: patByte = BYTE_ALT;
      default: patByte = idleByte;
    endcase
    rxIn = rdLsbFirst ? sfsRev8(xf.rxByte) : xf.rxByte;
    lane = sfsLane(addr_r[1:0], littleEndian);
    ackEv = (ackS_r[2] != ackS_r[1]);
    lastByte = (dcnt_r == DCNT_ONE);
  end

  // one byte outstanding at a time; the sequencer waits for the link's ack
  always_comb begin
    st_nxt = st_r;
    cmdBuf_nxt = cmdBuf_r;
    idx_nxt = idx_r;
    dcnt_nxt = dcnt_r;
    addr_nxt = addr_r;
    word_nxt = word_r;
    be_nxt = be_r;
    ackS_nxt = {ackS_r[1:0], xf.ackTgl};
    txByte_nxt = txByte_r;
    pend_nxt = pend_r;
    reqTgl_nxt = reqTgl_r;
    wvalid_nxt = wvalid_r;
    mReq_nxt = mReq_r;
    mWe_nxt = mWe_r;
    mAddr_nxt = mAddr_r;
    mBe_nxt = mBe_r;
    mWdata_nxt = mWdata_r;
    sel_nxt = sel_r;
    done_nxt = done_r & ~doneClr;
    case (st_r)
      ST_IDLE: begin
        // software owns the buffer only between transactions
        for (int i = 0; i < CMD_BYTES / 2; i++) begin
          if (cmdLowWe) begin
            cmdBuf_nxt[i] = cmdWrData[i*8 +: 8];
          end
          if (cmdHighWe) begin
            cmdBuf_nxt[i + CMD_BYTES / 2] = cmdWrData[i*8 +: 8];
          end
        end
        if (transactionGo) begin
          st_nxt = ST_CMD;
          sel_nxt = 1'b1;
          idx_nxt = '0;
          addr_nxt = dmaAddr;
          wvalid_nxt = 1'b0;
          be_nxt = BE_NONE;
          word_nxt = '0;
        end
      end
      ST_CMD: begin
        if (pend_r) begin
          if (ackEv) begin
            pend_nxt = 1'b0;
            idx_nxt = idx_r + 4'h1;
            if (!direction[idx_r[2:0]]) begin
              cmdBuf_nxt[idx_r[2:0]] = rxIn;
            end
          end
        end else if (idx_r == total) begin
          // data phase only after every command byte
          if (rdCount != DCNT_ZERO) begin
            st_nxt = ST_RDAT;
            dcnt_nxt = rdCount;
          end else if (wrCount != DCNT_ZERO) begin
            st_nxt = ST_WDAT;
            dcnt_nxt = wrCount;
          end else begin
            st_nxt = ST_FIN;
            sel_nxt = 1'b0;
          end
        end else begin
          pend_nxt = 1'b1;
          reqTgl_nxt = ~reqTgl_r;
          if (direction[idx_r[2:0]]) begin
            txByte_nxt = wrLsbFirst ? sfsRev8(cmdBuf_r[idx_r[2:0]]) : cmdBuf_r[idx_r[2:0]];
          end else begin
            txByte_nxt = patByte;
          end
        end
      end
      ST_RDAT: begin
        if (mReq_r) begin
          // memory stalls the link: no byte is asked for until the word is taken
          if (memAck) begin
            mReq_nxt = 1'b0;
            be_nxt = BE_NONE;
            word_nxt = '0;
            if (dcnt_r == DCNT_ZERO) begin
              st_nxt = ST_FIN;
              sel_nxt = 1'b0;
            end
          end
        end else if (pend_r) begin
          if (ackEv) begin
            pend_nxt = 1'b0;
            word_nxt[lane*8 +: 8] = rxIn;
            be_nxt[lane] = 1'b1;
            addr_nxt = addr_r + 32'h1;
            dcnt_nxt = dcnt_r - DCNT_ONE;
            if (addr_r[1:0] == LANE_LAST || lastByte) begin
              mReq_nxt = 1'b1;
              mWe_nxt = 1'b1;
              mAddr_nxt = {addr_r[31:2], 2'h0};
              mWdata_nxt = word_nxt;
              mBe_nxt = be_nxt;
            end
          end
        end else begin
          pend_nxt = 1'b1;
          reqTgl_nxt = ~reqTgl_r;
          txByte_nxt = patByte;
        end
      end
      ST_WDAT: begin
        if (mReq_r) begin
          if (memAck) begin
            mReq_nxt = 1'b0;
            word_nxt = memRdata;
            wvalid_nxt = 1'b1;
          end
        end else if (pend_r) begin
          if (ackEv) begin
            pend_nxt = 1'b0;
            addr_nxt = addr_r + 32'h1;
            dcnt_nxt = dcnt_r - DCNT_ONE;
            if (addr_r[1:0] == LANE_LAST) begin
              wvalid_nxt = 1'b0;
            end
            if (lastByte) begin
              st_nxt = ST_FIN;
              sel_nxt = 1'b0;
            end
          end
        end else if (!wvalid_r) begin
          mReq_nxt = 1'b1;
          mWe_nxt = 1'b0;
          mAddr_nxt = {addr_r[31:2], 2'h0};
          mBe_nxt = BE_ALL;
        end else begin
          pend_nxt = 1'b1;
          reqTgl_nxt = ~reqTgl_r;
          txByte_nxt = wrLsbFirst ? sfsRev8(word_r[lane*8 +: 8]) : word_r[lane*8 +: 8];
        end
      end
      ST_FIN: begin
        // select already dropped one cycle earlier
        done_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      for (int i = 0; i < CMD_BYTES; i++) begin
        cmdBuf_r[i] <= BYTE_ZERO;
      end
      idx_r <= '0;
      dcnt_r <= DCNT_ZERO;
      addr_r <= '0;
      word_r <= '0;
      be_r <= BE_NONE;
      ackS_r <= '0;
      txByte_r <= BYTE_ZERO;
      pend_r <= 1'b0;
      reqTgl_r <= 1'b0;
      wvalid_r <= 1'b0;
      mReq_r <= 1'b0;
      mWe_r <= 1'b0;
      mAddr_r <= '0;
      mBe_r <= BE_NONE;
      mWdata_r <= '0;
      sel_r <= 1'b0;
      done_r <= 1'b0;
      pwr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmdBuf_r <= cmdBuf_nxt;
      idx_r <= idx_nxt;
      dcnt_r <= dcnt_nxt;
      addr_r <= addr_nxt;
      word_r <= word_nxt;
      be_r <= be_nxt;
      ackS_r <= ackS_nxt;
      txByte_r <= txByte_nxt;
      pend_r <= pend_nxt;
      reqTgl_r <= reqTgl_nxt;
      wvalid_r <= wvalid_nxt;
      mReq_r <= mReq_nxt;
      mWe_r <= mWe_nxt;
      mAddr_r <= mAddr_nxt;
      mBe_r <= mBe_nxt;
      mWdata_r <= mWdata_nxt;
      sel_r <= sel_nxt;
      done_r <= done_nxt;
      pwr_r <= flashSupplySwitch;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_go_start;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == ST_IDLE && transactionGo) |=> (st_r == ST_CMD) && !flashSelectLine_n;
  endproperty
  a_go_start: assert property (p_go_start) else $error("go did not start");

  property p_go_ignored;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r inside {ST_CMD, ST_RDAT, ST_WDAT})
        |=> (st_r != ST_IDLE) && (idx_r >= $past(idx_r));
  endproperty
  a_go_ignored: assert property (p_go_ignored) else $error("run cut short");

  property p_cmd_first;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == ST_RDAT || st_r == ST_WDAT) |-> (idx_r == total);
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("data before command");

  property p_sel_held;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r inside {ST_CMD, ST_RDAT, ST_WDAT}) |-> !flashSelectLine_n;
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("select dropped early");

  property p_done_after_release;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(done_r) |-> flashSelectLine_n && $past(flashSelectLine_n) && ($past(st_r) == ST_FIN);
  endproperty
  a_done_after_release: assert property (p_done_after_release) else $error("done early");

  property p_done_sticky;
    @(posedge sys_clk) disable iff (!arst_n)
      (done_r && !doneClr) |=> done_r;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done lost");

  property p_rx_store;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r == ST_CMD && pend_r && ackEv && !direction[idx_r[2:0]])
        |=> (cmdBuf_r[$past(idx_r[2:0])] == $past(rxIn));
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("status byte not stored");

  property p_mem_write_phase;
    @(posedge sys_clk) disable iff (!arst_n)
      (memReq && memWe) |-> (st_r == ST_RDAT) && (memBe != BE_NONE);
  endproperty
  a_mem_write_phase: assert property (p_mem_write_phase) else $error("stray write");

endmodule : sfs_sequencer

// ===== tb/sfs_flash_model.sv
// partner: behavioural serial flash, any clock mode, msb first, counting answers
module sfs_flash_model (
  input wire logic selLine_n,
  input wire logic sck,
  input wire logic ph,
  input wire logic mosi,
  output logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx [0:15];
  logic [7:0] sh;
  logic [7:0] tx;
  logic sckEff;
  int n;
  int b;
  // modes 1 and 2 sample on the falling edge: fold them onto the rising one
  assign sckEff = sck ^ ph;
  // ****************************************
  // shifter
  // ****************************************
  // answer byte k of a frame is A0+k, so the bench can predict it
  initial begin
    n = 0;
    b = 0;
    miso = 1'b0;
  end
  always @(negedge selLine_n) begin
    n = 0;
    b = 0;
    tx = 8'hA0;
    miso = tx[7];
  end
  // no pull on the line: a released miso must not look like valid data
  always @(posedge selLine_n) miso = ~miso;
  // sample and count bits on the folded rising edge
  always @(posedge sckEff) if (!selLine_n) begin
    sh = {sh[6:0], mosi};
    b++;
    if (b == 8) begin
      rx[n] = sh;
      n++;
      b = 0;
      tx = 8'hA0 + 8'(n);
    end
  end
  // drive on the folded falling edge so the synced sample sees a stable bit
  always @(negedge sckEff) if (!selLine_n) miso = tx[7 - b];
endmodule : sfs_flash_model

// ===== tb/tb_top.sv
// testbench: command, status, data-phase and power checks of the sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, arst_n, linkClk, transactionGo, doneClr, transactionCompleteFlag, busy;
  logic cmdLowWe, cmdHighWe, wrLsbFirst, rdLsbFirst, littleEndian, flashSupplySwitch;
  logic flashPowerEn, flashSelectLine_n, flashSck, flashMosi, flashMiso, memReq, memWe, memAck;
  logic [31:0] cmdWrData, commandBytesLowWord, commandBytesHighWord, dmaAddr, memAddr;
  logic [31:0] memWdata, memRdata, mAddr, mData;
  logic [7:0] direction, idleByte;
  logic [2:0] cmdCount;
  logic mWe;
  logic [23:0] rdCount, wrCount;
  logic [1:0] xferMode, serialClockSourceSelect, idlePattern;
  logic [3:0] memBe, mBe;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] pat [0:3] = '{8'h00, 8'hFF, 8'hAA, 8'h5A};

  sfs_sequencer i_sfs_sequencer (.sys_clk, .arst_n, .linkClk, .transactionGo, .doneClr,
    .transactionCompleteFlag, .busy, .cmdLowWe, .cmdHighWe, .cmdWrData, .commandBytesLowWord,
    .commandBytesHighWord, .direction, .cmdCount, .rdCount, .wrCount, .dmaAddr, .xferMode,
    .serialClockSourceSelect, .wrLsbFirst, .rdLsbFirst, .idlePattern, .idleByte, .littleEndian,
    .flashSupplySwitch, .flashPowerEn, .flashSelectLine_n, .flashSck, .flashMosi, .flashMiso,
    .memReq, .memWe, .memAddr, .memBe, .memWdata, .memAck, .memRdata);
  sfs_flash_model i_sfs_flash_model (.selLine_n(flashSelectLine_n), .sck(flashSck),
    .ph(^xferMode), .mosi(flashMosi), .miso(flashMiso));

  // ****************************************
  // clocks, memory responder, tasks
  // ****************************************
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  initial #3 linkClk = 1'b0;
  always #7.5 linkClk = ~linkClk;
  // acks one cycle after each request, keeping the last one seen
  always @(negedge sys_clk) begin
    if (memReq === 1'b1 && memAck === 1'b0)
      {mAddr, mBe, mData, mWe} = {memAddr, memBe, memWdata, memWe};
    memAck = (memReq === 1'b1 && memAck === 1'b0);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic setCmd(input logic [31:0] lo, input logic [31:0] hi);
    @(negedge sys_clk) {cmdWrData, cmdLowWe} = {lo, 1'b1};
    @(negedge sys_clk) {cmdWrData, cmdLowWe, cmdHighWe} = {hi, 2'b01};
    @(negedge sys_clk) cmdHighWe = 1'b0;
  endtask : setCmd
  // a second go lands mid-run; the byte count shows it was ignored
  task automatic runTxn(input int nb);
    @(negedge sys_clk) transactionGo = 1'b1;
    @(negedge sys_clk) transactionGo = 1'b0;
    check(32'(busy), 32'h1);
    for (int i = 0; i < 4000 && transactionCompleteFlag !== 1'b1; i++)
      @(negedge sys_clk) transactionGo = (i == 8);
    check(32'(transactionCompleteFlag), 32'h1);
    check(32'(busy), 32'h0);
    check(32'(flashSelectLine_n), 32'h1);
    check(32'(i_sfs_flash_model.n), 32'(nb));
    @(negedge sys_clk) doneClr = 1'b1;
    @(negedge sys_clk) doneClr = 1'b0;
  endtask : runTxn
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000000 n_fail++;
    tally_and_finish();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {arst_n, transactionGo, doneClr, cmdLowWe, cmdHighWe, wrLsbFirst, rdLsbFirst} = '0;
    {littleEndian, flashSupplySwitch, cmdWrData, dmaAddr, memRdata, direction} = '0;
    {idleByte, cmdCount, rdCount, wrCount, xferMode, idlePattern} = '0;
    serialClockSourceSelect = 2'h3; // slowest source, miso sync margin
    repeat (3) @(negedge sys_clk);
    check({busy, flashSelectLine_n, memReq, transactionCompleteFlag}, 32'h4);
    arst_n = 1'b1;
    flashSupplySwitch = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(32'(flashPowerEn), 32'h1);
    setCmd(32'h0000009F, 32'h0);
    {direction, cmdCount} = {8'h01, 3'h5};
    runTxn(5);
    check(32'(i_sfs_flash_model.rx[0]), 32'h9F);
    check(commandBytesLowWord, 32'hA3A2A19F);
    check(commandBytesHighWord, 32'h000000A4);
    $display("test status read done");
    {idleByte, cmdCount} = {8'h5A, 3'h2};
    for (int p = 0; p < 4; p++) begin
      // every clock mode once, read bit order flipped in the upper two
      {idlePattern, wrLsbFirst, rdLsbFirst, xferMode} = {2'(p), p[0], p[1], 2'(p)};
      setCmd(32'h0000009F, 32'h0);
      runTxn(2);
      check(32'(i_sfs_flash_model.rx[0]), p[0] ? 32'hF9 : 32'h9F);
      check(32'(i_sfs_flash_model.rx[1]), 32'(pat[p]));
      check(commandBytesLowWord, {16'h0, (p[1] ? 8'h85 : 8'hA1), 8'h9F});
    end
    $display("test patterns and bit order done");
    setCmd(32'h00000003, 32'h0);
    {wrLsbFirst, rdLsbFirst, direction, cmdCount} = {2'b00, 8'hFF, 3'h1};
    {rdCount, dmaAddr, serialClockSourceSelect} = {24'h4, 32'h100, 2'h2};
    for (int e = 0; e < 2; e++) begin
      littleEndian = e[0];
      runTxn(5);
      check(mAddr, 32'h100);
      check(32'(mWe), 32'h1);
      check(32'(mBe), 32'hF);
      check(mData, e[0] ? 32'hA4A3A2A1 : 32'hA1A2A3A4);
    end
    $display("test read phase done");
    {rdCount, wrCount, memRdata} = {24'h0, 24'h2, 32'h44332211};
    for (int e = 0; e < 2; e++) begin
      {littleEndian, serialClockSourceSelect} = {e[0], 2'(e)};
      runTxn(3);
      check(mAddr, 32'h100);
      check(32'(mWe), 32'h0);
      check(32'(i_sfs_flash_model.rx[0]), 32'h03);
      check(32'(i_sfs_flash_model.rx[1]), e[0] ? 32'h11 : 32'h44);
      check(32'(i_sfs_flash_model.rx[2]), e[0] ? 32'h22 : 32'h33);
    end
    $display("test write phase done");
    flashSupplySwitch = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(32'(flashPowerEn), 32'h0);
    $display("test power switch done");
    tally_and_finish();
  end
endmodule : tb_top
